// File: hw/aic_pkg.sv
// aic_pkg: constants shared by the analog input control block.
// assumes one 100 MHz clock domain; all host and converter pins reach it through aic_sync.
`default_nettype none
package aic_pkg;

    // host bundle layout as seen through the synchroniser
    localparam int HB_W         = 16;
    localparam int HB_WR_N      = 0;
    localparam int HB_RD_N      = 1;
    localparam int HB_A0        = 2;
    localparam int HB_SEL_N     = 3;
    localparam int HB_DIR       = 4;
    localparam int HB_WD_LSB    = 5;
    localparam int HB_DATA_LSB  = 8;
    // strobes and select idle high
    localparam logic [HB_W-1:0] HB_RESET = 16'h000B;

    // converter bundle layout
    localparam int CB_W         = 14;
    localparam int CB_BUSY      = 0;
    localparam int CB_CE        = 1;
    localparam int CB_RES_LSB   = 2;
    localparam logic [CB_W-1:0] CB_RESET = 14'h0000;

    // word index decode
    localparam logic [2:0] IDX_CONTROL = 3'h0;
    localparam logic [2:0] IDX_STATUS  = 3'h0;
    localparam logic [2:0] IDX_RESULT  = 3'h1;

    // control register fields
    localparam int CTL_CHAN_LSB = 0;
    localparam int CTL_IRQ_EN   = 4;
    localparam int CTL_START    = 7;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // status register fields
    localparam int STS_IRQ_EN   = 4;
    localparam int STS_INT      = 6;
    localparam int STS_BUSY     = 7;

    // result width inside the 16-bit data word
    localparam int RES_W        = 12;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

endpackage
`default_nettype wire

// File: hw/aic_sync.sv
// aic_sync: three-stage synchroniser bank with agreement filter.
// assumes asynchronous inputs; output moves only when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module aic_sync #(
    parameter int              W         = 8,
    parameter logic [W-1:0]    RESET_VAL = '0
) (
    input  wire logic          clk_sys_i,
    input  wire logic          reset_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // s1 feeds only s2
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per bit: accept a level once two later stages agree
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            q_o <= RESET_VAL;
        else
            q_o <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
    end

endmodule
`default_nettype wire

// File: hw/aic_top.sv
// aic_top: byte-pair bridge plus analog input converter control.
// assumes host pins and converter pins are asynchronous to clk_sys_i;
// base address decode is done upstream, so every host strobe is ours.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - even write latches low byte only
// - odd write puts whole word out
// - even read fetches word, holds high
// - odd read returns held high byte
// - control, status and result answer only when device select active
// - decode index and direction into strobes
// - control holds channel, enable, start; reset clears
// - status shows busy, interrupt, enable readback
// - result word, top four bits zero
// - result is raw unsigned 12-bit code
// - start line is inverted start AND enable
// - channel field drives multiplexer select
// - hold while busy, sample otherwise
// - busy fall sets interrupt state flag
// - interrupt low when flag and enable
// - request out high until conversion done
// - enable low holds off conversions
// - direction high reads, low writes
module aic_top (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  buffered_byte_lines_i,
    output logic      [7:0]  buffered_byte_lines_o,
    output logic             buffered_byte_lines_oe_o,
    input  wire logic        byte_addr0_i,
    input  wire logic        host_rd_n_i,
    input  wire logic        host_wr_n_i,
    input  wire logic        analog_device_select_n_i,
    input  wire logic [2:0]  word_index_bits_i,
    input  wire logic        bus_read_direction_i,
    input  wire logic        adc_busy_i,
    input  wire logic [aic_pkg::RES_W-1:0] adc_result_i,
    input  wire logic        conv_enable_i,
    output logic             low_byte_write_strobe_o,
    output logic             high_byte_write_strobe_o,
    output logic             low_byte_read_strobe_o,
    output logic             high_byte_read_strobe_o,
    output logic             conv_control_write_o,
    output logic      [7:0]  word_bus_low_lines_o,
    output logic      [7:0]  word_bus_high_lines_o,
    output logic             converter_start_n_o,
    output logic      [1:0]  mux_select_o,
    output logic             sample_hold_o,
    output logic             done_irq_n_o,
    output logic             conversion_request_out_o
);
    import aic_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input synchronisation

    logic [HB_W-1:0] host_s;
    logic [CB_W-1:0] conv_s;

    // data rides with the strobes so both are aligned at the edge
    wire logic [HB_W-1:0] host_raw = {buffered_byte_lines_i,
                                      word_index_bits_i,
                                      bus_read_direction_i,
                                      analog_device_select_n_i,
                                      byte_addr0_i,
                                      host_rd_n_i,
                                      host_wr_n_i};
    wire logic [CB_W-1:0] conv_raw = {adc_result_i, conv_enable_i, adc_busy_i};

    aic_sync #(
        .W         (HB_W),
        .RESET_VAL (HB_RESET)
    ) u_host_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .d_i       (host_raw),
        .q_o       (host_s)
    );

    aic_sync #(
        .W         (CB_W),
        .RESET_VAL (CB_RESET)
    ) u_conv_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .d_i       (conv_raw),
        .q_o       (conv_s)
    );

    wire logic             wr_n    = host_s[HB_WR_N];
    wire logic             rd_n    = host_s[HB_RD_N];
    wire logic             a0      = host_s[HB_A0];
    wire logic             sel_n   = host_s[HB_SEL_N];
    wire logic             dir_rd  = host_s[HB_DIR];
    wire logic [2:0]       widx    = host_s[HB_WD_LSB +: 3];
    wire logic [7:0]       bdata   = host_s[HB_DATA_LSB +: 8];
    wire logic             busy    = conv_s[CB_BUSY];
    wire logic             cen     = conv_s[CB_CE];
    wire logic [RES_W-1:0] adc_res = conv_s[CB_RES_LSB +: RES_W];

    ////////////////////////////////////////////////////////////////////
    // strobe and busy edge detection

    logic wr_n_q_r;
    logic rd_n_q_r;
    logic busy_q_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            wr_n_q_r <= 1'b1;
            rd_n_q_r <= 1'b1;
            busy_q_r <= 1'b0;
        end
        else
        begin
            wr_n_q_r <= wr_n;
            rd_n_q_r <= rd_n;
            busy_q_r <= busy;
        end
    end

    wire logic wr_ev     = wr_n_q_r & ~wr_n;
    wire logic rd_ev     = rd_n_q_r & ~rd_n;
    wire logic busy_rise = ~busy_q_r & busy;
    wire logic busy_fall = busy_q_r & ~busy;

    ////////////////////////////////////////////////////////////////////
    // byte-pair bridge strobes

    wire logic lo_wr = wr_ev & ~a0;
    wire logic hi_wr = wr_ev & a0;
    wire logic lo_rd = rd_ev & ~a0;
    wire logic hi_rd = rd_ev & a0;

    ////////////////////////////////////////////////////////////////////
    // device decode

    // one decode shared by all three strobes
    function automatic logic hit(input logic       sel_n_f,
                                 input logic       dir_f,
                                 input logic       want_rd,
                                 input logic [2:0] idx_f,
                                 input logic [2:0] want_idx);
        hit = ~sel_n_f & (dir_f == want_rd) & (idx_f == want_idx);
    endfunction

    // direction high means a word bus read, low a write
    wire logic ctl_wr = hi_wr & hit(sel_n, dir_rd, 1'b0, widx, IDX_CONTROL);
    wire logic sts_rd = lo_rd & hit(sel_n, dir_rd, 1'b1, widx, IDX_STATUS);
    wire logic res_rd = lo_rd & hit(sel_n, dir_rd, 1'b1, widx, IDX_RESULT);

    ////////////////////////////////////////////////////////////////////
    // low byte holding latch

    logic [7:0] low_hold_r;

    // host keeps low-then-high order; a lone odd write reuses the last low byte
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            low_hold_r <= IDLE_BYTE;
        else if (lo_wr)
            low_hold_r <= bdata;
    end

    ////////////////////////////////////////////////////////////////////
    // control register

    logic [15:0] control_r;
    logic [15:0] wr_word;

    assign wr_word = {bdata, low_hold_r};

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            control_r <= CONTROL_RESET;
        else if (ctl_wr)
            control_r <= wr_word;
    end

    wire logic irq_en    = control_r[CTL_IRQ_EN];
    wire logic start_bit = control_r[CTL_START];

    ////////////////////////////////////////////////////////////////////
    // conversion tracking

    logic [RES_W-1:0] result_r;
    logic             int_state_r;
    logic             req_r;
    logic             busy_seen_r;

    // capture the code as busy falls; code passes unaltered
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            result_r <= '0;
        else if (busy_fall)
            result_r <= adc_res;
    end

    // a result read clears the flag, but a same-cycle end of conversion wins
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            int_state_r <= 1'b0;
        else if (busy_fall)
            int_state_r <= 1'b1;
        else if (res_rd)
            int_state_r <= 1'b0;
    end

    // request stays up across the hold-off and the whole busy period
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            req_r <= 1'b0;
        else if (ctl_wr & wr_word[CTL_START])
            req_r <= 1'b1;
        else if (busy_fall & busy_seen_r)
            req_r <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            busy_seen_r <= 1'b0;
        else if (ctl_wr & wr_word[CTL_START])
            busy_seen_r <= 1'b0;
        else if (busy_rise & req_r)
            busy_seen_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // converter side outputs

    // enable low keeps the start line high, so nothing converts
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            converter_start_n_o      <= 1'b1;
            mux_select_o             <= 2'h0;
            sample_hold_o            <= 1'b0;
            done_irq_n_o             <= 1'b1;
            conversion_request_out_o <= 1'b0;
        end
        else
        begin
            converter_start_n_o      <= ~(start_bit & cen);
            mux_select_o             <= control_r[CTL_CHAN_LSB +: 2];
            sample_hold_o            <= busy;
            done_irq_n_o             <= ~(int_state_r & irq_en);
            conversion_request_out_o <= req_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // word fetched from the device on an even read

    logic [15:0] status_word;
    logic [15:0] result_word;
    logic [15:0] rd_word;

    always_comb
    begin
        status_word             = 16'h0000;
        status_word[STS_BUSY]   = busy;
        status_word[STS_INT]    = int_state_r;
        status_word[STS_IRQ_EN] = irq_en;
    end

    // upper four bits are tied low
    assign result_word = {{(16-RES_W){1'b0}}, result_r};

    always_comb
    begin
        if (sts_rd)
            rd_word = status_word;
        else if (res_rd)
            rd_word = result_word;
        else
            rd_word = 16'h0000; // unselected device floats to zero
    end

    ////////////////////////////////////////////////////////////////////
    // high byte holding register and host read data

    logic [7:0] high_hold_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            high_hold_r <= IDLE_BYTE;
        else if (lo_rd)
            high_hold_r <= rd_word[15:8];
    end

    // odd read never touches the device, so flags are not disturbed
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            buffered_byte_lines_o <= IDLE_BYTE;
        else if (lo_rd)
            buffered_byte_lines_o <= rd_word[7:0];
        else if (hi_rd)
            buffered_byte_lines_o <= high_hold_r;
    end

    // drive only for the span of the host read strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            buffered_byte_lines_oe_o <= 1'b0;
        else if (rd_ev)
            buffered_byte_lines_oe_o <= 1'b1;
        else if (rd_n)
            buffered_byte_lines_oe_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // word bus view and strobe pulses

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            word_bus_low_lines_o  <= IDLE_BYTE;
            word_bus_high_lines_o <= IDLE_BYTE;
        end
        else if (hi_wr)
        begin
            word_bus_low_lines_o  <= low_hold_r;
            word_bus_high_lines_o <= bdata;
        end
        else if (lo_rd)
        begin
            word_bus_low_lines_o  <= rd_word[7:0];
            word_bus_high_lines_o <= rd_word[15:8];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            low_byte_write_strobe_o  <= 1'b0;
            high_byte_write_strobe_o <= 1'b0;
            low_byte_read_strobe_o   <= 1'b0;
            high_byte_read_strobe_o  <= 1'b0;
            conv_control_write_o     <= 1'b0;
        end
        else
        begin
            low_byte_write_strobe_o  <= lo_wr;
            high_byte_write_strobe_o <= hi_wr;
            low_byte_read_strobe_o   <= lo_rd;
            high_byte_read_strobe_o  <= hi_rd;
            conv_control_write_o     <= ctl_wr;
        end
    end

endmodule
`default_nettype wire

// File: sim/aic_top_asserts.sv
// aic_top_asserts: port-level temporal checks for aic_top.
// assumes one clock domain, sync active-high reset, bound onto every aic_top.
`timescale 1ns/1ps
`default_nettype none
module aic_top_asserts (
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic       adc_busy_i,
    input wire logic       conv_enable_i,
    input wire logic       buffered_byte_lines_oe_o,
    input wire logic       low_byte_write_strobe_o,
    input wire logic       high_byte_write_strobe_o,
    input wire logic       low_byte_read_strobe_o,
    input wire logic       high_byte_read_strobe_o,
    input wire logic       conv_control_write_o,
    input wire logic [7:0] word_bus_low_lines_o,
    input wire logic       converter_start_n_o,
    input wire logic [1:0] mux_select_o,
    input wire logic       sample_hold_o,
    input wire logic       done_irq_n_o,
    input wire logic       conversion_request_out_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_ctl_word;
        high_byte_write_strobe_o;
    endsequence
    sequence s_mux_follows;
        ##1 mux_select_o == $past(word_bus_low_lines_o[1:0]);
    endsequence
    property p_rst;
        $past(reset_i) |-> mux_select_o == 2'h0 && converter_start_n_o && done_irq_n_o
            && !conversion_request_out_o;
    endproperty
    property p_lw;
        low_byte_write_strobe_o |-> !buffered_byte_lines_oe_o ##1 !low_byte_write_strobe_o;
    endproperty
    property p_cw;
        conv_control_write_o |-> s_ctl_word ##0 s_mux_follows;
    endproperty
    property p_rd;
        low_byte_read_strobe_o || high_byte_read_strobe_o |-> buffered_byte_lines_oe_o;
    endproperty
    property p_req;
        $rose(conversion_request_out_o) |-> $past(conv_control_write_o);
    endproperty
    property p_go;
        $fell(converter_start_n_o) |-> $past(conv_enable_i);
    endproperty
    property p_sh;
        $rose(sample_hold_o) |-> $past(adc_busy_i, 2);
    endproperty
    property p_done;
        $fell(sample_hold_o) && conversion_request_out_o |-> ##[0:2] !conversion_request_out_o;
    endproperty
    property p_irq;
        $fell(done_irq_n_o) |-> !sample_hold_o;
    endproperty
    property p_dir;
        buffered_byte_lines_oe_o |-> !low_byte_write_strobe_o && !high_byte_write_strobe_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_lw: assert property (p_lw) else $error("low write strobe bad");
    a_cw: assert property (p_cw) else $error("control write bad");
    a_rd: assert property (p_rd) else $error("read without drive");
    a_req: assert property (p_req) else $error("request without command");
    a_go: assert property (p_go) else $error("start while disabled");
    a_sh: assert property (p_sh) else $error("hold without busy");
    a_done: assert property (p_done) else $error("request stuck");
    a_irq: assert property (p_irq) else $error("interrupt while busy");
    a_dir: assert property (p_dir) else $error("drive during write");
endmodule
bind aic_top aic_top_asserts u_chk (.clk_sys_i, .reset_i, .adc_busy_i, .conv_enable_i,
    .buffered_byte_lines_oe_o, .low_byte_write_strobe_o, .high_byte_write_strobe_o,
    .low_byte_read_strobe_o, .high_byte_read_strobe_o, .conv_control_write_o,
    .word_bus_low_lines_o, .converter_start_n_o, .mux_select_o, .sample_hold_o,
    .done_irq_n_o, .conversion_request_out_o);
`default_nettype wire

// File: sim/aic_adc_model.sv
// aic_adc_model: behavioural 12-bit converter behind the start line.
// assumes start is taken on the low-going edge; code_i set before start.
`timescale 1ns/1ps
`default_nettype none
module aic_adc_model #(
    parameter int CONV_CYC = 20
) (
    input  wire logic        clk_sys_i,
    input  wire logic        converter_start_n_i,
    input  wire logic [11:0] code_i,
    output logic             adc_busy_o,
    output logic [11:0]      adc_result_o
);
    int   cnt_r = 0;
    logic start_q_r = 1'b1;
    initial adc_busy_o = 1'b0;
    initial adc_result_o = 12'h000;
    always @(posedge clk_sys_i)
    begin
        start_q_r <= converter_start_n_i;
        if (start_q_r && !converter_start_n_i && cnt_r == 0)
            cnt_r <= CONV_CYC;
        else if (cnt_r > 0)
            cnt_r <= cnt_r - 1;
        adc_busy_o <= cnt_r > 1;
        // result lines churn mid-conversion, settle one cycle before busy falls
        adc_result_o <= (cnt_r > 2) ? ~adc_result_o : code_i;
    end
endmodule
`default_nettype wire

// File: sim/aic_top_test.sv
// aic_top_test: self-checking bench for aic_top over the byte-pair host bus.
// assumes the converter model answers the start line; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module aic_top_test;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  bd_i = 8'h00;
    logic        a0 = 1'b0;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        sel_n = 1'b1;
    logic [2:0]  idx = 3'h0;
    logic        dir = 1'b0;
    logic        conv_en = 1'b0;
    logic [11:0] code = 12'h000;
    logic        busy;
    logic [11:0] result;
    logic [7:0]  bd_o;
    logic        oe, start_n, req, sh, irq_n;
    logic [1:0]  mux;
    logic [7:0]  wb_lo, wb_hi;
    logic [8:0]  seen;
    int          err_count = 0;
    int          cmp_count = 0;
    int          tmo = 0;
    aic_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .buffered_byte_lines_i(bd_i),
        .buffered_byte_lines_o(bd_o), .buffered_byte_lines_oe_o(oe), .byte_addr0_i(a0),
        .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .analog_device_select_n_i(sel_n),
        .word_index_bits_i(idx), .bus_read_direction_i(dir), .adc_busy_i(busy),
        .adc_result_i(result), .conv_enable_i(conv_en), .low_byte_write_strobe_o(),
        .high_byte_write_strobe_o(), .low_byte_read_strobe_o(), .high_byte_read_strobe_o(),
        .conv_control_write_o(), .word_bus_low_lines_o(wb_lo), .word_bus_high_lines_o(wb_hi),
        .converter_start_n_o(start_n), .mux_select_o(mux), .sample_hold_o(sh),
        .done_irq_n_o(irq_n), .conversion_request_out_o(req));
    aic_adc_model u_adc (.clk_sys_i(clk_sys_i), .converter_start_n_i(start_n),
        .code_i(code), .adc_busy_o(busy), .adc_result_o(result));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // qualifiers settle two cycles before the strobe, held until it rises
    task automatic host(input logic r, input logic a, input logic s, input logic dr,
                        input logic [2:0] ix, input logic [7:0] d);
        a0 <= a;
        sel_n <= s;
        dir <= dr;
        idx <= ix;
        bd_i <= d;
        cyc(2);
        if (r)
            rd_n <= 1'b0;
        else
            wr_n <= 1'b0;
        cyc(8);
        seen = {oe, bd_o};
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        cyc(8);
    endtask
    task automatic wpair(input logic s, input logic dr, input logic [15:0] d);
        host(1'b0, 1'b0, s, dr, 3'h0, d[7:0]);
        host(1'b0, 1'b1, s, dr, 3'h0, d[15:8]);
    endtask
    task automatic rd(input logic a, input logic s, input logic [2:0] ix, input logic [7:0] e);
        host(1'b1, a, s, 1'b1, ix, 8'h00);
        check({7'h00, seen}, {8'h01, e});
    endtask
    task automatic conv(input logic [11:0] c, input logic [7:0] ctl, input logic [7:0] st);
        for (int i = 0; i < 200 && req !== 1'b0; i++)
            cyc(1);
        cyc(3);
        check({15'h0000, irq_n}, {15'h0000, ~ctl[4]});
        rd(1'b0, 1'b0, 3'h0, st);
        wpair(1'b0, 1'b0, {8'h00, ctl & 8'h7F});
        check({15'h0000, start_n}, 16'h0001);
        rd(1'b0, 1'b0, 3'h1, c[7:0]);
        rd(1'b1, 1'b0, 3'h1, {4'h0, c[11:8]});
        check({15'h0000, irq_n}, 16'h0001);
    endtask
    always @(posedge clk_sys_i)
    begin
        tmo++;
        if (tmo == 6000)
        begin
            err_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(3);
        reset_i <= 1'b0;
        cyc(2);
        check({11'h000, start_n, irq_n, req, mux}, 16'h0018);
        $display("test reset done");
        code <= 12'hFFF;
        wpair(1'b0, 1'b0, 16'h0092);
        check({wb_hi, wb_lo}, 16'h0092);
        cyc(30);
        check({11'h000, start_n, req, mux, sh}, 16'h001C);
        conv_en <= 1'b1;
        cyc(8);
        check({15'h0000, start_n}, 16'h0000);
        conv(12'hFFF, 8'h92, 8'h50);
        $display("test held conversion done");
        code <= 12'h800;
        wpair(1'b0, 1'b0, 16'h0081);
        check({15'h0000, start_n}, 16'h0000);
        conv(12'h800, 8'h81, 8'h40);
        $display("test direct conversion done");
        wpair(1'b1, 1'b0, 16'h0003);
        wpair(1'b0, 1'b1, 16'h0003);
        check({14'h0000, mux}, 16'h0001);
        rd(1'b0, 1'b1, 3'h1, 8'h00);
        // a wrongly taken even read would have held the result's high byte
        rd(1'b1, 1'b1, 3'h1, 8'h00);
        $display("test refused access done");
        reset_i <= 1'b1;
        cyc(3);
        reset_i <= 1'b0;
        cyc(2);
        check({11'h000, start_n, irq_n, req, mux}, 16'h0018);
        $display("test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
